// ### design/lcs_cfg.svh
// constants of the line channel service sequencer
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH

// register map of the software bus, byte addresses
`define LCS_OFF_CTRL 8'h00
`define LCS_OFF_LCT_IDX 8'h04
`define LCS_OFF_LCT_DATA 8'h08
`define LCS_OFF_RX_DESC 8'h0C
`define LCS_OFF_TX_DESC 8'h10
`define LCS_OFF_STATUS 8'h14

// control register fields
`define LCS_CTRL_START_RX 0
`define LCS_CTRL_START_TX 1

// line control table layout
`define LCS_LCT_BYTES 256
`define LCS_LCT_HALF 128
`define LCS_LCT_CFG_RX 8'h02
`define LCS_LCT_CFG_TX 8'h22
`define LCS_LCT_SPD_RX 8'h28
`define LCS_LCT_SPD_TX 8'hA8
`define LCS_LCT_DSC 8'h14

// adapter line register numbers
`define LCS_LR_DATA 3'h1
`define LCS_LR_DSC 3'h2
`define LCS_LR_SPD 3'h4
`define LCS_LR_CFG 3'h6

// fields of the data set and adapter control register
`define LCS_DSC_RX_ON 0
`define LCS_DSC_TX_ON 1

// setup steps of a channel program
`define LCS_STEP_CFG 2'h0
`define LCS_STEP_SPD 2'h1
`define LCS_STEP_DSC 2'h2

`define LCS_CH_RX 1'b0
`define LCS_CH_TX 1'b1

`endif

// ### design/lcs_pkg.sv
// types of the line channel service sequencer
package lcs_pkg;

	typedef enum logic [7:0] {
		LCS_IDLE = 8'h01,
		LCS_SETUP = 8'h02,
		LCS_RESTORE = 8'h04,
		LCS_RECEIVE_CHAR_OP = 8'h08,
		LCS_STORE = 8'h10,
		LCS_FETCH = 8'h20,
		LCS_SEND = 8'h40,
		LCS_WAIT = 8'h80
	} lcs_state_e;

	typedef struct packed {
		lcs_state_e st;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic [255:0][7:0] line_control_table;
		logic [7:0] lct_idx;
		logic [15:0] rx_addr;
		logic [15:0] rx_range;
		logic [15:0] tx_addr;
		logic [15:0] tx_range;
		logic rx_last;
		logic tx_last;
		logic rx_lost;
		logic [1:0] start_pend;
		logic [1:0] started;
		logic chan;
		logic [1:0] step;
		logic fetch_busy;
		logic [1:0][7:0] work;
		logic [7:0] cur;
		logic lr_wr;
		logic [2:0] lr_num;
		logic lr_chan;
		logic [7:0] lr_data;
		logic rx_take;
		logic mem_wr;
		logic mem_rd;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
	} lcs_proc_s;

	typedef struct packed {
		logic [7:0] char_cfg;
		logic [1:0][7:0] spd;
		logic [7:0] dsc;
		logic [7:0] rx_data;
		logic svc_rx;
		logic rx_overrun;
		logic [7:0] tx_data;
		logic tx_full;
		logic svc_tx;
		logic tx_valid;
		logic [7:0] tx_out;
	} lcs_adpt_s;

endpackage : lcs_pkg

// ### design/lcs_if.sv
// link between channel sequencer and line adapter
`timescale 1ns/1ps
interface lcs_if;
	logic svc_req_rx;
	logic svc_req_tx;
	logic [7:0] rx_data;
	logic rx_take;
	logic lr_wr;
	logic [2:0] lr_num;
	logic lr_chan;
	logic [7:0] lr_data;

	modport proc (
		input svc_req_rx, svc_req_tx, rx_data,
		output rx_take, lr_wr, lr_num, lr_chan, lr_data
	);
	modport adpt (
		output svc_req_rx, svc_req_tx, rx_data,
		input rx_take, lr_wr, lr_num, lr_chan, lr_data
	);
endinterface : lcs_if

// ### design/lcs_adapter.sv
// line adapter end: line registers, service requests, character path
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module lcs_adapter
	import lcs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// sequencer link
	lcs_if.adpt lnk,
	// line side receive
	input wire logic line_rx_valid,
	input wire logic [7:0] line_rx_data,
	// line side transmit
	input wire logic line_tx_ready,
	output logic line_tx_valid,
	output logic [7:0] line_tx_data,
	// line configuration seen by the line logic
	output logic [7:0] char_config_line_reg,
	output logic [7:0] speed_or_sync_rx,
	output logic [7:0] speed_or_sync_tx,
	output logic [7:0] dataset_adapter_ctrl_reg,
	output logic rx_overrun
);

	lcs_adpt_s r;
	lcs_adpt_s next_r;

	always_comb begin
		next_r = r;
		next_r.tx_valid = 1'b0;
		if (lnk.lr_wr) begin
			case (lnk.lr_num)
				`LCS_LR_CFG: next_r.char_cfg = lnk.lr_data;
				`LCS_LR_SPD: next_r.spd[lnk.lr_chan] = lnk.lr_data;
				`LCS_LR_DSC: next_r.dsc = lnk.lr_data;
				`LCS_LR_DATA: begin
					if (lnk.lr_chan == `LCS_CH_TX) begin
						next_r.tx_data = lnk.lr_data;
						next_r.tx_full = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// sent on its own once the line can take it
		if (r.tx_full && line_tx_ready && !r.tx_valid) begin
			next_r.tx_valid = 1'b1;
			next_r.tx_out = r.tx_data;
			next_r.tx_full = 1'b0;
		end
		if (lnk.rx_take)
			next_r.svc_rx = 1'b0;
		// arrival beats a take in the same cycle
		if (line_rx_valid && r.dsc[`LCS_DSC_RX_ON]) begin
			next_r.rx_data = line_rx_data;
			next_r.svc_rx = 1'b1;
			if (r.svc_rx && !lnk.rx_take)
				next_r.rx_overrun = 1'b1;
		end
		next_r.svc_tx = next_r.dsc[`LCS_DSC_TX_ON] && !next_r.tx_full;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign lnk.svc_req_rx = r.svc_rx;
	assign lnk.svc_req_tx = r.svc_tx;
	assign lnk.rx_data = r.rx_data;
	assign line_tx_valid = r.tx_valid;
	assign line_tx_data = r.tx_out;
	assign char_config_line_reg = r.char_cfg;
	assign speed_or_sync_rx = r.spd[`LCS_CH_RX];
	assign speed_or_sync_tx = r.spd[`LCS_CH_TX];
	assign dataset_adapter_ctrl_reg = r.dsc;
	assign rx_overrun = r.rx_overrun;

endmodule : lcs_adapter

// ### design/lcs_sequencer.sv
// channel service sequencer: line control table, channel programs, host side
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module lcs_sequencer
	import lcs_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// adapter link
	lcs_if.proc lnk,
	// host memory: store of received characters
	output logic mem_wr,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	// host memory: fetch of characters to send
	output logic mem_rd,
	input wire logic mem_rd_ack,
	input wire logic [7:0] mem_rd_data
);

	lcs_proc_s r;
	lcs_proc_s next_r;

	////////////////////////////////////////////////////////////////
	// helpers

	// table byte holding a channel's character configuration
	function automatic logic [7:0] cfg_byte(input logic ch);
		cfg_byte = (ch == `LCS_CH_TX) ? `LCS_LCT_CFG_TX : `LCS_LCT_CFG_RX;
	endfunction : cfg_byte

	// table byte holding a channel's speed, sync or fill character
	function automatic logic [7:0] spd_byte(input logic ch);
		spd_byte = (ch == `LCS_CH_TX) ? `LCS_LCT_SPD_TX : `LCS_LCT_SPD_RX;
	endfunction : spd_byte

	// byte lanes of a write, lane 0 lowest
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	logic bus_req;
	logic [31:0] wmask;
	logic [31:0] desc_new;
	logic [1:0] start_set;

	assign bus_req = wb_cyc_i && wb_stb_i && !r.wb_ack;
	assign wmask = lane_mask(wb_sel_i);
	assign start_set = (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `LCS_OFF_CTRL) ? wb_dat_i[1:0] : 2'b00;

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_r = r;
		desc_new = 32'h0000_0000;
		next_r.wb_ack = bus_req;
		next_r.lr_wr = 1'b0;
		next_r.rx_take = 1'b0;
		next_r.mem_wr = 1'b0;
		next_r.mem_rd = 1'b0;

		// register bus; one cycle to ack, unmapped reads give zero
		if (bus_req) begin
			next_r.wb_dat = 32'h0000_0000;
			case (wb_adr_i)
				`LCS_OFF_CTRL: begin
					if (wb_we_i && wb_sel_i[0]) begin
						next_r.start_pend = r.start_pend | wb_dat_i[1:0];
					end
					next_r.wb_dat = {16'h0000, r.st, 2'b00, r.started, 2'b00, r.start_pend};
				end
				`LCS_OFF_LCT_IDX: begin
					if (wb_we_i && wb_sel_i[0])
						next_r.lct_idx = wb_dat_i[7:0];
					next_r.wb_dat = {24'h00_0000, r.lct_idx};
				end
				`LCS_OFF_LCT_DATA: begin
					// host writes the table; firmware bytes are its own care
					if (wb_we_i && wb_sel_i[0])
						next_r.line_control_table[r.lct_idx] = wb_dat_i[7:0];
					next_r.wb_dat = {24'h00_0000, r.line_control_table[r.lct_idx]};
				end
				`LCS_OFF_RX_DESC: begin
					desc_new = ({r.rx_range, r.rx_addr} & ~wmask) | (wb_dat_i & wmask);
					if (wb_we_i) begin
						next_r.rx_addr = desc_new[15:0];
						next_r.rx_range = desc_new[31:16];
						next_r.rx_last = 1'b0;
					end
					next_r.wb_dat = {r.rx_range, r.rx_addr};
				end
				`LCS_OFF_TX_DESC: begin
					desc_new = ({r.tx_range, r.tx_addr} & ~wmask) | (wb_dat_i & wmask);
					if (wb_we_i) begin
						next_r.tx_addr = desc_new[15:0];
						next_r.tx_range = desc_new[31:16];
						next_r.tx_last = 1'b0;
					end
					next_r.wb_dat = {r.tx_range, r.tx_addr};
				end
				`LCS_OFF_STATUS: begin
					next_r.wb_dat = {29'h0000_0000, r.rx_lost, r.tx_last, r.rx_last};
				end
				default: begin
				end
			endcase
		end

		// channel programs; one activation at a time up to its wait
		case (r.st)
			LCS_IDLE: begin
				if (r.start_pend[`LCS_CH_RX] || r.start_pend[`LCS_CH_TX]) begin
					next_r.chan = r.start_pend[`LCS_CH_RX] ? `LCS_CH_RX : `LCS_CH_TX;
					// a start order landing in the same cycle stays pending
					next_r.start_pend[next_r.chan] = start_set[next_r.chan];
					next_r.step = `LCS_STEP_CFG;
					next_r.st = LCS_SETUP;
				end else if (lnk.svc_req_rx && r.started[`LCS_CH_RX]) begin
					next_r.chan = `LCS_CH_RX;
					next_r.st = LCS_RESTORE;
				end else if (lnk.svc_req_tx && r.started[`LCS_CH_TX]) begin
					next_r.chan = `LCS_CH_TX;
					next_r.st = LCS_RESTORE;
				end
			end
			LCS_SETUP: begin
				// one output per line register, control register last
				next_r.lr_wr = 1'b1;
				next_r.lr_chan = r.chan;
				case (r.step)
					`LCS_STEP_CFG: begin
						next_r.lr_num = `LCS_LR_CFG;
						next_r.lr_data = r.line_control_table[cfg_byte(r.chan)];
						next_r.step = `LCS_STEP_SPD;
					end
					`LCS_STEP_SPD: begin
						next_r.lr_num = `LCS_LR_SPD;
						next_r.lr_data = r.line_control_table[spd_byte(r.chan)];
						next_r.step = `LCS_STEP_DSC;
					end
					default: begin
						next_r.lr_num = `LCS_LR_DSC;
						next_r.lr_data = r.line_control_table[`LCS_LCT_DSC];
						next_r.started[r.chan] = 1'b1;
						next_r.st = LCS_WAIT;
					end
				endcase
			end
			LCS_RESTORE: begin
				// resume in the loop just after the wait
				next_r.cur = r.work[r.chan];
				next_r.st = (r.chan == `LCS_CH_TX) ? LCS_FETCH : LCS_RECEIVE_CHAR_OP;
			end
			LCS_RECEIVE_CHAR_OP: begin
				next_r.cur = lnk.rx_data;
				next_r.rx_take = 1'b1;
				next_r.st = LCS_STORE;
			end
			LCS_STORE: begin
				// a full block drops the character and flags it
				if (r.rx_range != 16'h0000) begin
					next_r.mem_wr = 1'b1;
					next_r.mem_addr = r.rx_addr;
					next_r.mem_wdata = r.cur;
					next_r.rx_addr = r.rx_addr + 16'h0001;
					next_r.rx_range = r.rx_range - 16'h0001;
					next_r.rx_last = (r.rx_range == 16'h0001);
				end else begin
					next_r.rx_lost = 1'b1;
				end
				next_r.work[r.chan] = r.cur;
				next_r.st = LCS_WAIT;
			end
			LCS_FETCH: begin
				if (!r.fetch_busy) begin
					if (r.tx_range == 16'h0000) begin
						next_r.st = LCS_WAIT;
					end else begin
						next_r.mem_rd = 1'b1;
						next_r.mem_addr = r.tx_addr;
						next_r.fetch_busy = 1'b1;
					end
				end else if (mem_rd_ack) begin
					next_r.fetch_busy = 1'b0;
					next_r.cur = mem_rd_data;
					next_r.tx_addr = r.tx_addr + 16'h0001;
					next_r.tx_range = r.tx_range - 16'h0001;
					next_r.tx_last = (r.tx_range == 16'h0001);
					next_r.st = LCS_SEND;
				end
			end
			LCS_SEND: begin
				next_r.lr_wr = 1'b1;
				next_r.lr_num = `LCS_LR_DATA;
				next_r.lr_chan = `LCS_CH_TX;
				next_r.lr_data = r.cur;
				next_r.work[r.chan] = r.cur;
				next_r.st = LCS_WAIT;
			end
			LCS_WAIT: begin
				// one cycle lets the adapter drop a served request
				next_r.st = LCS_IDLE;
			end
			default: begin
				next_r.st = LCS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
			r.st <= LCS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign wb_ack_o = r.wb_ack;
	assign wb_dat_o = r.wb_dat;
	assign lnk.rx_take = r.rx_take;
	assign lnk.lr_wr = r.lr_wr;
	assign lnk.lr_num = r.lr_num;
	assign lnk.lr_chan = r.lr_chan;
	assign lnk.lr_data = r.lr_data;
	assign mem_wr = r.mem_wr;
	assign mem_rd = r.mem_rd;
	assign mem_addr = r.mem_addr;
	assign mem_wdata = r.mem_wdata;

endmodule : lcs_sequencer

// ### verification/lcs_assertions.sv
// concurrent checks on the sequencer to adapter link
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module lcs_assertions (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link signals
	input wire logic svc_req_rx,
	input wire logic svc_req_tx,
	input wire logic [7:0] rx_data,
	input wire logic rx_take,
	input wire logic lr_wr,
	input wire logic [2:0] lr_num,
	input wire logic lr_chan,
	input wire logic [7:0] lr_data
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// transmit-on as last loaded; the checker sees only the link
	logic tx_on;
	always_ff @(posedge ref_clk) begin
		if (rst)
			tx_on <= 1'b0;
		else if (lr_wr && lr_num == `LCS_LR_DSC)
			tx_on <= lr_data[`LCS_DSC_TX_ON];
	end
	////////////////////////////////////////////////////////////////
	AST_SETUP_ORDER: assert property (lr_wr && lr_num == `LCS_LR_CFG |=>
		lr_wr && lr_num == `LCS_LR_SPD ##1 lr_wr && lr_num == `LCS_LR_DSC)
		else $error("setup writes out of order");
	AST_SETUP_CHAN: assert property (lr_wr && lr_num == `LCS_LR_CFG |=> $stable(lr_chan)[*2])
		else $error("setup channel changed mid sequence");
	AST_LR_LEGAL: assert property (lr_wr |-> lr_num inside {3'h1, 3'h2, 3'h4, 3'h6})
		else $error("write to unexpected line register");
	AST_SEND_TX: assert property (lr_wr && lr_num == `LCS_LR_DATA |-> lr_chan)
		else $error("character sent on receive channel");
	AST_TX_ONLY_ON: assert property (svc_req_tx |-> tx_on)
		else $error("transmit request while transmit off");
	AST_TX_REQ_DROP: assert property (lr_wr && lr_num == `LCS_LR_DATA |=> !svc_req_tx)
		else $error("transmit request held with data register full");
	AST_TAKE_CAUSE: assert property (rx_take |-> svc_req_rx && !lr_wr)
		else $error("receive take without pending character");
	AST_TAKE_DROP: assert property (rx_take |=> !svc_req_rx && !rx_take)
		else $error("receive request kept after take");
	AST_ONE_AT_TIME: assert property (lr_wr && lr_num == `LCS_LR_DATA |-> !rx_take ##1 !lr_wr)
		else $error("two activations overlap");
endmodule : lcs_assertions

// ### verification/line_channel_service_sequencer_tb.sv
// bench: both ends joined, driven over wishbone and the line side
`timescale 1ns/1ps
module line_channel_service_sequencer_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, q;
	logic wb_ack_o, mem_wr, mem_rd, line_tx_valid, rx_overrun;
	logic mem_rd_ack = 1'b0, line_rx_valid = 1'b0, line_tx_ready = 1'b1;
	logic [7:0] mem_rd_data = 8'h00, line_rx_data = 8'h00, mem_wdata, line_tx_data;
	logic [7:0] cfg, spd_rx, spd_tx, dsc;
	logic [15:0] mem_addr;
	logic [23:0] wq[$];
	logic [7:0] txq[$];
	int bad_count = 0, checks = 0;
	lcs_if lnk();
	lcs_sequencer lcs_sequencer_inst (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .lnk(lnk), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rd(mem_rd), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data));
	lcs_adapter lcs_adapter_inst (.ref_clk(ref_clk), .rst(rst), .lnk(lnk), .line_rx_valid(line_rx_valid),
		.line_rx_data(line_rx_data), .line_tx_ready(line_tx_ready), .line_tx_valid(line_tx_valid),
		.line_tx_data(line_tx_data), .char_config_line_reg(cfg), .speed_or_sync_rx(spd_rx),
		.speed_or_sync_tx(spd_tx), .dataset_adapter_ctrl_reg(dsc), .rx_overrun(rx_overrun));
	lcs_assertions lcs_assertions_inst (.ref_clk(ref_clk), .rst(rst), .svc_req_rx(lnk.svc_req_rx),
		.svc_req_tx(lnk.svc_req_tx), .rx_data(lnk.rx_data), .rx_take(lnk.rx_take), .lr_wr(lnk.lr_wr),
		.lr_num(lnk.lr_num), .lr_chan(lnk.lr_chan), .lr_data(lnk.lr_data));
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	// host memory answers a fetch one cycle later with addr+0x11
	always @(posedge ref_clk) begin
		mem_rd_ack <= mem_rd;
		mem_rd_data <= mem_addr[7:0] + 8'h11;
		if (mem_wr === 1'b1)
			wq.push_back({mem_addr, mem_wdata});
		if (line_tx_valid === 1'b1)
			txq.push_back(line_tx_data);
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one classic cycle; read data taken at the ack edge only
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hf;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge ref_clk);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask : wb
	task automatic tw(input logic [7:0] i, input logic [7:0] v);
		wb(1'b1, 8'h04, {24'h0, i});
		wb(1'b1, 8'h08, {24'h0, v});
	endtask : tw
	task automatic rxc(input logic [7:0] d);
		line_rx_valid <= 1'b1;
		line_rx_data <= d;
		@(posedge ref_clk);
		line_rx_valid <= 1'b0;
		repeat (20) @(posedge ref_clk);
	endtask : rxc
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		wb(1'b0, 8'h14, 32'h0);
		chk("status", q, 32'h0);
		wb(1'b1, 8'h20, 32'hffff_ffff);
		wb(1'b0, 8'h20, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test reset done");
		tw(8'h02, 8'h2b);
		tw(8'h22, 8'h4d);
		tw(8'h28, 8'h61);
		tw(8'ha8, 8'h7e);
		tw(8'h14, 8'h03);
		tw(8'hff, 8'he5);
		wb(1'b1, 8'h04, 32'h0000_00ff);
		wb(1'b0, 8'h08, 32'h0);
		chk("table top byte", q, 32'h0000_00e5);
		wb(1'b1, 8'h0c, 32'h0002_0100);
		wb(1'b1, 8'h00, 32'h0000_0001);
		repeat (10) @(posedge ref_clk);
		chk("cfg rx", {24'h0, cfg}, 32'h0000_002b);
		chk("speed rx", {24'h0, spd_rx}, 32'h0000_0061);
		chk("dsc", {24'h0, dsc}, 32'h0000_0003);
		$display("test rx start done");
		rxc(8'hc3);
		rxc(8'h3c);
		rxc(8'h5a);
		chk("store count", wq.size(), 32'h2);
		chk("store 0", {8'h0, wq[0]}, 32'h0001_00c3);
		chk("store 1", {8'h0, wq[1]}, 32'h0001_013c);
		wb(1'b0, 8'h14, 32'h0);
		chk("rx last lost", q & 32'h5, 32'h5);
		$display("test receive done");
		wb(1'b1, 8'h10, 32'h0002_0200);
		wb(1'b1, 8'h00, 32'h0000_0002);
		repeat (60) @(posedge ref_clk);
		chk("cfg tx", {24'h0, cfg}, 32'h0000_004d);
		chk("speed tx", {24'h0, spd_tx}, 32'h0000_007e);
		chk("sent count", txq.size(), 32'h2);
		chk("sent 0", {24'h0, txq[0]}, 32'h0000_0011);
		chk("sent 1", {24'h0, txq[1]}, 32'h0000_0012);
		wb(1'b0, 8'h00, 32'h0);
		chk("started", q & 32'h30, 32'h30);
		$display("test transmit done");
		tw(8'h14, 8'h01);
		wb(1'b1, 8'h00, 32'h0000_0002);
		repeat (20) @(posedge ref_clk);
		chk("tx req off", {31'h0, lnk.svc_req_tx}, 32'h0);
		$display("test transmit off done");
		chk("no overrun", {31'h0, rx_overrun}, 32'h0);
		line_rx_valid <= 1'b1;
		line_rx_data <= 8'h91;
		@(posedge ref_clk);
		rxc(8'h92);
		chk("overrun", {31'h0, rx_overrun}, 32'h1);
		$display("test overrun done");
		finish_test();
	end
endmodule : line_channel_service_sequencer_tb
